// file: src/mode_reset_pkg.sv
package mode_reset_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLOCK_NS          = 100;  // 10 MHz core clock
  localparam int unsigned STANDBY_MAX_US    = 8;    // enable fall to sleep
  localparam int unsigned STANDBY_CYC_RAW   = (STANDBY_MAX_US * 1000) / CLOCK_NS;
  localparam int unsigned STANDBY_CYC       = (STANDBY_CYC_RAW < 1) ? 1 : STANDBY_CYC_RAW;
  localparam int unsigned CS_HIGH_MIN_US    = 5;    // host gap between frames
  localparam int unsigned CS_HIGH_CYC       = (CS_HIGH_MIN_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;

  // ****************************************************************
  // layout and reset values
  // ****************************************************************
  localparam int unsigned CTRL_W            = 6;    // half-bridge control bits
  localparam logic [5:0]  CTRL_RESET        = 6'h00;
  localparam logic        FLAG_RESET        = 1'b0; // not-reset flag after reset
  localparam int unsigned FRAME_W           = 16;   // serial frame length
  localparam int unsigned FLAG_POS          = 0;    // flag position in status

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,  // logic supply low, ctrl, flag and bit count cleared
    ST_SLEEP  = 2'b01,  // enable low
    ST_NORMAL = 2'b11   // enable high
  } mode_t;

endpackage : mode_reset_pkg

// file: src/driver_mode_reset_control.sv
`timescale 1ns/1ns
`default_nettype none

module driver_mode_reset_control
  import mode_reset_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        ENABLE,           // enable pin, pulled low outside
  input  wire logic        LOGIC_SUPPLY_OK,  // above on threshold comparator
  input  wire logic        POWER_SUPPLY_OK,  // power-stage in range
  input  wire logic        SCLK,
  input  wire logic        CHIP_SELECT_LOW,
  input  wire logic        SDI,
  output logic             SERIAL_DATA_OUT,
  output logic             SERIAL_DATA_OUT_OE_N,
  output logic [5:0]       BRIDGE_DRIVE,     // gated drives to power stage
  output logic             OUTPUTS_HIGH_Z,
  output logic             CHARGE_PUMP_ON,
  output logic             NOT_RESET_FLAG
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [5:0] sync1;  // first stage, only read by sync2
  logic [5:0] sync2;  // settled copies
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      // chip select idles high, so no false select edge after reset
      sync1 <= 6'h02;
      sync2 <= 6'h02;
    end
    else
    begin
      sync1 <= {ENABLE, LOGIC_SUPPLY_OK, POWER_SUPPLY_OK,
                SCLK, CHIP_SELECT_LOW, SDI};
      sync2 <= sync1;
    end
  end

  logic en_s;
  logic vdd_ok;
  logic vs_ok;
  logic sclk_s;
  logic csn_s;
  logic sdi_s;
  assign {en_s, vdd_ok, vs_ok, sclk_s, csn_s, sdi_s} = sync2;

  // ****************************************************************
  // mode state
  // ****************************************************************
  mode_t       mode;       // current mode
  mode_t       next_mode;
  logic [5:0]  ctrl;       // stored half-bridge control bits
  logic [5:0]  next_ctrl;
  logic        flag;       // not-reset flag
  logic        next_flag;
  logic [15:0] shreg;      // serial shift register
  logic [15:0] next_shreg;
  logic [4:0]  bitcnt;     // bits seen in frame
  logic [4:0]  next_bitcnt;
  logic        sclk_q;     // edge detect on settled clock
  logic        csn_q;
  logic        serial_data_out;
  logic        next_sdo;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  assign sclk_rise = sclk_s & ~sclk_q;
  assign sclk_fall = ~sclk_s & sclk_q;
  assign cs_rise   = csn_s & ~csn_q;
  assign cs_fall   = ~csn_s & csn_q;

  // next-state logic for mode, control bits and serial shifting
  always_comb
  begin
    next_mode   = mode;
    next_ctrl   = ctrl;
    next_flag   = flag;
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_sdo    = serial_data_out;
    case (mode)
      ST_OFF:
      begin
        // control bits, flag and bit count held cleared while supply is low
        next_ctrl   = CTRL_RESET;
        next_flag   = FLAG_RESET;
        next_bitcnt = 5'h00;
        if (vdd_ok)
          next_mode = ST_SLEEP;    // reinitialise
      end
      ST_SLEEP:
      begin
        // banks at reset contents; flag stays zero to report it
        next_ctrl   = CTRL_RESET;
        next_flag   = FLAG_RESET;
        next_bitcnt = 5'h00;
        // a floating enable pin is pulled low outside, so it reads low
        // here and the block stays asleep
        if (!vdd_ok)
          next_mode = ST_OFF;
        else if (en_s)
          next_mode = ST_NORMAL;
      end
      ST_NORMAL:
      begin
        if (!vdd_ok)
          next_mode = ST_OFF;
        else if (!en_s)
          next_mode = ST_SLEEP;    // one cycle plus sync
        else
        begin
          // frame bookkeeping; power-stage state is not looked at here
          // so a dropout leaves ctrl alone
          if (cs_fall)
          begin
            next_bitcnt = 5'h00;
            next_sdo    = flag;    // status bit leads the frame
          end
          else if (!csn_s && sclk_rise && bitcnt < 5'(FRAME_W))
          begin
            next_shreg  = {shreg[14:0], sdi_s};
            next_bitcnt = bitcnt + 5'h01;
          end
          else if (!csn_s && sclk_fall)
            next_sdo = shreg[15];
          if (cs_rise && bitcnt == 5'(FRAME_W))
          begin
            // msb set = write control bits; any valid frame sets flag
            if (shreg[15])
              next_ctrl = shreg[5:0];
            next_flag = 1'b1;
          end
        end
      end
      default: next_mode = ST_OFF;
    endcase
  end

  // registers of the mode group
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      mode   <= ST_OFF;
      ctrl   <= CTRL_RESET;
      flag   <= FLAG_RESET;
      shreg  <= 16'h0000;
      bitcnt <= 5'h00;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      serial_data_out    <= 1'b0;
    end
    else
    begin
      mode   <= next_mode;
      ctrl   <= next_ctrl;
      flag   <= next_flag;
      shreg  <= next_shreg;
      bitcnt <= next_bitcnt;
      sclk_q <= sclk_s;
      csn_q  <= csn_s;
      serial_data_out    <= next_sdo;
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  logic       next_oe_n;
  logic [5:0] next_drive;
  logic       next_hiz;
  always_comb
  begin
    // data out only while selected in normal mode
    next_oe_n  = !(mode == ST_NORMAL && !csn_s);
    // power-stage fault gates drives but keeps ctrl
    next_hiz   = (mode != ST_NORMAL) || !vs_ok;
    next_drive = next_hiz ? 6'h00 : ctrl;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      SERIAL_DATA_OUT      <= 1'b0;
      SERIAL_DATA_OUT_OE_N <= 1'b1;
      BRIDGE_DRIVE         <= 6'h00;
      OUTPUTS_HIGH_Z       <= 1'b1;
      CHARGE_PUMP_ON       <= 1'b0;
      NOT_RESET_FLAG       <= 1'b0;
    end
    else
    begin
      SERIAL_DATA_OUT      <= serial_data_out;
      SERIAL_DATA_OUT_OE_N <= next_oe_n;
      BRIDGE_DRIVE         <= next_drive;
      OUTPUTS_HIGH_Z       <= next_hiz;
      CHARGE_PUMP_ON       <= (mode == ST_NORMAL);
      NOT_RESET_FLAG       <= flag;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sleep_clears_ctrl_a: assert property (
    (mode == ST_SLEEP) |=> (ctrl == CTRL_RESET))
    else $error("control bits not cleared in sleep");
  enable_low_sleep_a: assert property (
    (!en_s && vdd_ok) |-> ##[1:2] (mode != ST_NORMAL))
    else $error("sleep not reached in time");
  supply_low_off_a: assert property (
    !vdd_ok |=> (mode == ST_OFF))
    else $error("supply loss did not stop block");
  off_clears_flag_a: assert property (
    (mode == ST_OFF) |=> (flag == 1'b0))
    else $error("flag not cleared after supply loss");
  sleep_flag_zero_a: assert property (
    (mode == ST_SLEEP) ##1 (mode == ST_NORMAL) |-> (flag == 1'b0))
    else $error("enable reset not reported");
  vs_keeps_ctrl_a: assert property (
    (mode == ST_NORMAL && !vs_ok && en_s && vdd_ok && !cs_rise)
      |=> $stable(ctrl))
    else $error("control lost on power-stage dropout");
  vs_fault_hiz_a: assert property (
    (!vs_ok) |=> (OUTPUTS_HIGH_Z && BRIDGE_DRIVE == 6'h00))
    else $error("outputs live during power-stage fault");
  sdo_idle_a: assert property (
    csn_s |=> SERIAL_DATA_OUT_OE_N)
    else $error("data out driven while deselected");
  pump_normal_a: assert property (
    (mode == ST_NORMAL) |=> CHARGE_PUMP_ON)
    else $error("charge pump off in normal mode");
  off_hiz_a: assert property (
    (mode == ST_OFF) |=> OUTPUTS_HIGH_Z)
    else $error("outputs live with supply low");

  // ****************************************************************
  // further checks on drives, select and refused frames
  // ****************************************************************
  // checks use the settled copies, so they see what the logic sees;
  // pin timing below one clock period is not modelled here
  // drives follow the stored bits once the stage is healthy again
  drive_follows_ctrl_a: assert property (
    (mode == ST_NORMAL && vs_ok) |=> (BRIDGE_DRIVE == $past(ctrl)))
    else $error("drives do not follow control bits");
  // outside normal mode the banks stay at reset contents
  banks_inactive_a: assert property (
    (mode != ST_NORMAL) |=> (ctrl == CTRL_RESET))
    else $error("control bits live outside normal mode");
  // a frame shorter than 16 bits must not touch the control bits
  short_frame_a: assert property (
    (mode == ST_NORMAL && en_s && vdd_ok && cs_rise
      && bitcnt != 5'(FRAME_W)) |=> $stable(ctrl))
    else $error("short frame changed control bits");
  // the pump stops whenever sleep is entered
  sleep_pump_off_a: assert property (
    (mode == ST_SLEEP) |=> !CHARGE_PUMP_ON)
    else $error("charge pump running in sleep");
  // no drive at all while the block is not in normal mode
  sleep_no_drive_a: assert property (
    (mode != ST_NORMAL) |=> (BRIDGE_DRIVE == 6'h00))
    else $error("drives live outside normal mode");
  // selected in normal mode: the data line must be driven
  sdo_driven_a: assert property (
    (mode == ST_NORMAL && !csn_s) |=> !SERIAL_DATA_OUT_OE_N)
    else $error("data out not driven while selected");

  wake_c:  cover property ((mode == ST_SLEEP) ##1 (mode == ST_NORMAL));
  // enable fall seen as a step from normal into sleep
  sleep_c: cover property ((mode == ST_NORMAL) ##1 (mode == ST_SLEEP));
  write_c: cover property (cs_rise && bitcnt == 5'(FRAME_W) && shreg[15]);
  fault_c: cover property ((mode == ST_NORMAL) && !vs_ok);

endmodule : driver_mode_reset_control

`default_nettype wire

// file: verification/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// host side of the serial link
// ****************************************************************
module host_model
  import mode_reset_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic SERIAL_DATA_OUT,
  input  wire logic SERIAL_DATA_OUT_OE_N,
  output logic      SCLK,
  output logic      CHIP_SELECT_LOW,
  output logic      SDI
);
  logic last_bit;   // level last seen on the line
  logic sdo_wire;   // line as the host sees it
  logic first_bit;  // first bit of the last frame
  logic oe_mid;     // enable seen inside the last frame
  // a released line toggles, so a stale value never matches
  assign sdo_wire = SERIAL_DATA_OUT_OE_N ? ~last_bit : SERIAL_DATA_OUT;
  initial
  begin
    SCLK            = 1'b0;
    CHIP_SELECT_LOW = 1'b1;
    SDI             = 1'b0;
    last_bit        = 1'b0;
  end
  // remember the line for the released case
  always @(posedge CLOCK)
    last_bit <= sdo_wire;
  // 1 MHz serial clock, gap kept before every frame
  task automatic frame(input logic [15:0] word, input int nbits);
    repeat (CS_HIGH_CYC) @(negedge CLOCK);
    CHIP_SELECT_LOW = 1'b0;
    repeat (5) @(negedge CLOCK);
    first_bit = sdo_wire;
    oe_mid    = SERIAL_DATA_OUT_OE_N;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      SDI = word[i];
      repeat (5) @(negedge CLOCK);
      SCLK = 1'b1;
      repeat (5) @(negedge CLOCK);
      SCLK = 1'b0;
    end
    repeat (5) @(negedge CLOCK);
    CHIP_SELECT_LOW = 1'b1;
    SDI             = 1'b0;
  endtask : frame
endmodule : host_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import mode_reset_pkg::*;
();
  logic CLOCK = 1'b0, SYS_RST = 1'b1, en_val = 1'b0, en_drive = 1'b1;
  logic logic_ok = 1'b1, power_ok = 1'b1, sclk, csl, sdi, serial_data_out, oe_n;
  logic hz, pump, flag;
  logic [5:0]  drive;
  logic [5:0]  ctrl;  // last control value accepted
  logic [31:0] r;     // random draw
  tri0         en_pin; // pull-down stands for the pin's own
  int miscompares = 0, samples_checked = 0;
  assign en_pin = en_drive ? en_val : 1'bz;
  initial forever #50 CLOCK = ~CLOCK;
  driver_mode_reset_control dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .ENABLE(en_pin), .LOGIC_SUPPLY_OK(logic_ok), .POWER_SUPPLY_OK(power_ok),
    .SCLK(sclk), .CHIP_SELECT_LOW(csl), .SDI(sdi), .SERIAL_DATA_OUT(serial_data_out),
    .SERIAL_DATA_OUT_OE_N(oe_n), .BRIDGE_DRIVE(drive),
    .OUTPUTS_HIGH_Z(hz), .CHARGE_PUMP_ON(pump), .NOT_RESET_FLAG(flag));
  host_model host (.CLOCK(CLOCK), .SERIAL_DATA_OUT(serial_data_out),
    .SERIAL_DATA_OUT_OE_N(oe_n), .SCLK(sclk), .CHIP_SELECT_LOW(csl),
    .SDI(sdi));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // drives reach the stage only in normal mode with power in range
  function automatic logic [5:0] exp_drive(input logic [5:0] c,
                                           input logic en, input logic pw);
    return (en && pw) ? c : 6'h00;
  endfunction : exp_drive
  task automatic idle(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : idle
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge CLOCK);
    miscompares++;
    end_sim();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h7A84));
    idle(5);
    SYS_RST = 1'b0;
    idle(10);
    check(drive, 6'h00);
    check(hz, 1'b1);
    check(oe_n, 1'b1);
    host.frame(16'h803F, 16);
    idle(10);
    check(drive, 6'h00);
    check(pump, 1'b0);
    en_val = 1'b1;
    idle(10);
    check(pump, 1'b1);
    // corners first, then random control words
    for (int i = 0; i < 8; i++)
    begin
      r    = $urandom;
      ctrl = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : r[5:0];
      host.frame({1'b1, r[14:6], ctrl}, 16);
      check(host.first_bit, i != 0);
      check(host.oe_mid, 1'b0);
      idle(10);
      check(drive, exp_drive(ctrl, 1'b1, power_ok));
      check(flag, 1'b1);
      check(oe_n, 1'b1);
    end
    host.frame({1'b1, 9'h000, ~ctrl}, 15);  // short frame is dropped
    idle(10);
    check(drive, ctrl);
    power_ok = 1'b0;
    idle(10);
    check(drive, exp_drive(ctrl, 1'b1, power_ok));
    check(hz, 1'b1);
    power_ok = 1'b1;
    idle(10);
    check(drive, ctrl);
    en_val = 1'b0;
    idle(STANDBY_CYC);
    check(drive, 6'h00);
    check(pump, 1'b0);
    en_val = 1'b1;
    idle(10);
    check(drive, 6'h00);
    host.frame(16'h8015, 16);
    check(host.first_bit, 1'b0);
    en_drive = 1'b0;  // pin left floating
    idle(STANDBY_CYC);
    check(pump, 1'b0);
    check(drive, 6'h00);
    en_drive = 1'b1;
    logic_ok = 1'b0;
    idle(10);
    check(hz, 1'b1);
    host.frame(16'h802A, 16);
    check(host.oe_mid, 1'b1);
    check(drive, 6'h00);
    logic_ok = 1'b1;
    idle(10);
    check(flag, 1'b0);
    host.frame(16'h8001, 16);
    check(host.first_bit, 1'b0);
    idle(10);
    check(drive, 6'h01);
    end_sim();
  end
endmodule : tb
`default_nettype wire
